// ---- ovt_consts.vh ----
/*
 * constants for one overvoltage stage timing, event and fault log block.
 * assumes the including module runs on a 50 mhz clock.
 */
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
// What this block does
// (R1) delay type selector: code 1 fixed delay, code 2 inverse delay; fixed is default
// (R2) fixed mode trips after programmed delay in 5 ms steps, default 40 ms
// (R3) fixed delay of zero makes the stage instant, no start-to-trip delay
// (R4) inverse mode uses time dial k in 10 ms steps, default 50 ms
// (R5) inverse mode uses exponent on voltage ratio, default 1.00, inverse only
// (R6) release delay in 5 ms steps, default 60 ms, holds start when enabled
// (R7) delayed release selector: yes holds start until release expiry, no clears at once
// (R8) timer reset yes clears counter after full quiet release; no clears on drop
// (R9) continue selector keeps operate counter running until release delay elapses
// (R10) counting during release never trips unless pick-up returns first
// (R11) start, trip, blocked changes make on/off events, masked per event
// (R12) four stages, each reporting six events under its own block identifier
// (R13) each event carries time stamp and process measurement values
// (R14) per stage log of last twelve records, written only on on events
// (R15) record holds time, event, fault type, three voltages, remaining time, group
// (R16) inverse operate time equals k over (ratio to exponent minus one)
// (R17) start only while block inactive; block at pick-up gives blocked instead
// (R18) instant operation asserts trip together with start
// (R19) counters advance on a 5 ms tick, compared once per tick
`ifndef OVT_CONSTS_VH
`define OVT_CONSTS_VH
`define OVT_CLK_HZ 50000000
`define OVT_TICK_US 5000
`define OVT_TICK_CYCLES ((`OVT_CLK_HZ / 1000000) * `OVT_TICK_US)
`define OVT_TICK_W 18
`define OVT_SEL_NO 2'h1
`define OVT_SEL_YES 2'h2
`define OVT_TYPE_FIXED 2'h1
`define OVT_TYPE_INVERSE 2'h2
`define OVT_DEF_OP_STEPS 18'h00008
`define OVT_DEF_K 13'h0005
`define OVT_DEF_EXP 12'h064
`define OVT_DEF_REL_STEPS 15'h000C
`define OVT_OP_W 19
`define OVT_REL_W 15
`define OVT_K_W 13
`define OVT_DEN_W 24
`define OVT_DEN_FRAC 16
`define OVT_MAX_STEPS 19'h57E40
`define OVT_EV_START_ON 3'h0
`define OVT_EV_START_OFF 3'h1
`define OVT_EV_TRIP_ON 3'h2
`define OVT_EV_TRIP_OFF 3'h3
`define OVT_EV_BLOCK_ON 3'h4
`define OVT_EV_BLOCK_OFF 3'h5
`define OVT_TS_W 48
`define OVT_V_W 16
`define OVT_LOG_DEPTH 12
`define OVT_LOG_AW 4
`define OVT_LOG_LAST 4'hB
`define OVT_REC_W 124
`endif

// ---- ovt_log_mem.v ----
/*
 * small record memory for the fault log: one write port, registered read.
 * assumes writer and reader share the clock; no reset on the array.
 */
`timescale 1ns/100ps
module ovt_log_mem #(
  parameter WIDTH = 124,
  parameter DEPTH = 12,
  parameter AW = 4
) (
  input wire clock_i,
  input wire enable_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

  always @(posedge clock_i) begin
    if (enable_i) begin
      if (wr_en_i) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      // out-of-range addresses read zero rather than undefined data
      if (rd_addr_i < DEPTH) begin
        rd_data_o <= mem_reg[rd_addr_i];
      end else begin
        rd_data_o <= {WIDTH{1'b0}};
      end
    end
  end
endmodule // ovt_log_mem

// ---- ovt_stage.v ----
/*
 * one overvoltage stage: operate and release timing, event generation and
 * a twelve-record fault log. the system instantiates it four times with
 * different STAGE_ID values. pick-up, block, time stamp, voltages and the
 * inverse-time power term come from the surrounding measurement logic,
 * synchronous to clock_i.
 */
`timescale 1ns/100ps
`include "ovt_consts.vh"
module ovt_stage #(
  parameter [1:0] STAGE_ID = 2'h0,
  parameter TICK_CYCLES = `OVT_TICK_CYCLES
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire enable_i,
  input wire pickup_i,
  input wire block_i,
  input wire [1:0] delay_type_i,
  input wire [17:0] op_delay_steps_i,
  input wire [`OVT_K_W-1:0] time_dial_k_i,
  input wire [`OVT_DEN_W-1:0] ratio_pow_minus1_i,
  input wire [`OVT_REL_W-1:0] release_steps_i,
  input wire [1:0] delayed_release_i,
  input wire [1:0] timer_reset_i,
  input wire [1:0] continue_count_i,
  input wire [2:0] on_mask_i,
  input wire [2:0] off_mask_i,
  input wire [`OVT_TS_W-1:0] timestamp_i,
  input wire [2:0] fault_type_i,
  input wire [`OVT_V_W-1:0] volt_now_i,
  input wire [`OVT_V_W-1:0] volt_pre20_i,
  input wire [`OVT_V_W-1:0] volt_pre200_i,
  input wire [2:0] setting_group_i,
  input wire [`OVT_LOG_AW-1:0] log_rd_addr_i,
  output wire start_o,
  output wire trip_o,
  output wire blocked_o,
  output reg event_valid_o,
  output reg [1:0] event_stage_o,
  output reg [2:0] event_code_o,
  output reg [`OVT_TS_W-1:0] event_time_o,
  output reg [`OVT_V_W-1:0] event_volt_o,
  output reg [`OVT_V_W-1:0] event_pre20_o,
  output reg [`OVT_V_W-1:0] event_pre200_o,
  output reg [`OVT_OP_W-1:0] remaining_steps_o,
  output reg [3:0] log_count_o,
  output wire [`OVT_REC_W-1:0] log_rd_data_o
);
  //--------------------------------------------------------------------
  // tick
  //--------------------------------------------------------------------
  reg [`OVT_TICK_W-1:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= {`OVT_TICK_W{1'b0}};
    end else if (enable_i) begin
      if (tick) begin // [R19]
        tick_cnt_reg <= {`OVT_TICK_W{1'b0}};
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------
  // operate target
  //--------------------------------------------------------------------
  wire inverse = (delay_type_i == `OVT_TYPE_INVERSE); // [R1]
  // k is in 10 ms units, steps are 5 ms, denominator is fixed point
  wire [31:0] inv_num = {2'h0, time_dial_k_i, 1'b0, {`OVT_DEN_FRAC{1'b0}}}; // [R4]
  wire [31:0] inv_den = {8'h00, ratio_pow_minus1_i}; // [R5]
  wire [31:0] inv_quot = (inv_den == 32'h0) ? 32'hFFFFFFFF : inv_num / inv_den; // [R16]
  wire [`OVT_OP_W-1:0] inv_steps = (inv_quot > {13'h0, `OVT_MAX_STEPS}) ?
    `OVT_MAX_STEPS : inv_quot[`OVT_OP_W-1:0];
  wire [`OVT_OP_W-1:0] target = inverse ? inv_steps : {1'b0, op_delay_steps_i}; // [R2]
  wire instant = !inverse && (op_delay_steps_i == 18'h0); // [R3]

  //--------------------------------------------------------------------
  // timing core
  //--------------------------------------------------------------------
  reg start_reg, trip_reg, blocked_reg, releasing_reg;
  reg [`OVT_OP_W-1:0] op_cnt_reg;
  reg [`OVT_REL_W-1:0] rel_cnt_reg;
  reg start_next, trip_next, blocked_next, releasing_next;
  reg [`OVT_OP_W-1:0] op_cnt_next;
  reg [`OVT_REL_W-1:0] rel_cnt_next;
  wire active = pickup_i && !block_i;
  wire rel_done = (rel_cnt_reg >= release_steps_i);

  always @* begin
    start_next = start_reg;
    trip_next = trip_reg;
    releasing_next = releasing_reg;
    op_cnt_next = op_cnt_reg;
    rel_cnt_next = rel_cnt_reg;
    blocked_next = pickup_i && block_i; // [R17]
    if (active) begin
      start_next = 1'b1; // [R17]
      releasing_next = 1'b0;
      rel_cnt_next = {`OVT_REL_W{1'b0}};
      if (instant) begin
        trip_next = 1'b1; // [R18]
      end else if (tick) begin
        if (op_cnt_reg < target) begin
          op_cnt_next = op_cnt_reg + 1'b1;
        end
        // compare after this tick's count so the delay is exact
        if (op_cnt_reg + 1'b1 >= target) begin
          trip_next = 1'b1; // [R2]
        end
      end
    end else begin
      trip_next = 1'b0; // [R10]
      if (start_reg || releasing_reg) begin
        releasing_next = 1'b1;
        if (delayed_release_i != `OVT_SEL_YES || block_i) begin
          start_next = 1'b0; // [R7]
        end
        if (timer_reset_i != `OVT_SEL_YES) begin
          op_cnt_next = {`OVT_OP_W{1'b0}}; // [R8]
        end
        if (tick) begin
          if (rel_done) begin
            start_next = 1'b0; // [R6]
            releasing_next = 1'b0;
            op_cnt_next = {`OVT_OP_W{1'b0}}; // [R8]
          end else begin
            rel_cnt_next = rel_cnt_reg + 1'b1;
            // counting here can never trip: trip needs pick-up back
            if (continue_count_i == `OVT_SEL_YES && op_cnt_reg < target) begin
              op_cnt_next = op_cnt_reg + 1'b1; // [R9]
            end
          end
        end
      end
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      blocked_reg <= 1'b0;
      releasing_reg <= 1'b0;
      op_cnt_reg <= {`OVT_OP_W{1'b0}};
      rel_cnt_reg <= {`OVT_REL_W{1'b0}};
    end else if (enable_i) begin
      start_reg <= start_next;
      trip_reg <= trip_next;
      blocked_reg <= blocked_next;
      releasing_reg <= releasing_next;
      op_cnt_reg <= op_cnt_next;
      rel_cnt_reg <= rel_cnt_next;
    end
  end

  assign start_o = start_reg;
  assign trip_o = trip_reg;
  assign blocked_o = blocked_reg;

  //--------------------------------------------------------------------
  // events
  //--------------------------------------------------------------------
  // pending flags queue simultaneous events; one leaves per cycle
  reg start_d_reg, trip_d_reg, blocked_d_reg;
  reg [5:0] pend_reg;
  wire [5:0] new_ev = {
    blocked_d_reg & ~blocked_reg, ~blocked_d_reg & blocked_reg,
    trip_d_reg & ~trip_reg, ~trip_d_reg & trip_reg,
    start_d_reg & ~start_reg, ~start_d_reg & start_reg}; // [R11]
  reg [2:0] sel_code;
  reg sel_any;
  integer i;

  always @* begin
    sel_code = `OVT_EV_START_ON;
    sel_any = 1'b0;
    for (i = 5; i >= 0; i = i - 1) begin
      if (pend_reg[i]) begin
        sel_code = i[2:0];
        sel_any = 1'b1;
      end
    end
  end

  wire [5:0] sel_onehot = sel_any ? (6'h01 << sel_code) : 6'h00;
  wire sel_is_on = !sel_code[0];
  wire sel_stored = sel_is_on ? on_mask_i[sel_code[2:1]] : off_mask_i[sel_code[2:1]];
  wire [`OVT_OP_W-1:0] remaining = (op_cnt_reg < target) ? target - op_cnt_reg :
    {`OVT_OP_W{1'b0}};

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_d_reg <= 1'b0;
      trip_d_reg <= 1'b0;
      blocked_d_reg <= 1'b0;
      pend_reg <= 6'h00;
      event_valid_o <= 1'b0;
      event_stage_o <= 2'h0;
      event_code_o <= 3'h0;
      event_time_o <= {`OVT_TS_W{1'b0}};
      event_volt_o <= {`OVT_V_W{1'b0}};
      event_pre20_o <= {`OVT_V_W{1'b0}};
      event_pre200_o <= {`OVT_V_W{1'b0}};
      remaining_steps_o <= {`OVT_OP_W{1'b0}};
    end else if (enable_i) begin
      start_d_reg <= start_reg;
      trip_d_reg <= trip_reg;
      blocked_d_reg <= blocked_reg;
      // a new event wins over the clear of the one being sent
      pend_reg <= (pend_reg & ~sel_onehot) | new_ev;
      event_valid_o <= sel_any && sel_stored; // [R11]
      if (sel_any) begin
        event_stage_o <= STAGE_ID; // [R12]
        event_code_o <= sel_code;
        event_time_o <= timestamp_i; // [R13]
        event_volt_o <= volt_now_i;
        event_pre20_o <= volt_pre20_i;
        event_pre200_o <= volt_pre200_i;
        remaining_steps_o <= remaining;
      end
    end
  end

  //--------------------------------------------------------------------
  // fault log
  //--------------------------------------------------------------------
  reg [`OVT_LOG_AW-1:0] wr_ptr_reg;
  wire log_wr = sel_any && sel_is_on; // [R14]
  wire [`OVT_REC_W-1:0] record = {timestamp_i, sel_code, fault_type_i, volt_pre20_i,
    volt_now_i, volt_pre200_i, remaining, setting_group_i}; // [R15]

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {`OVT_LOG_AW{1'b0}};
      log_count_o <= 4'h0;
    end else if (enable_i && log_wr) begin
      wr_ptr_reg <= (wr_ptr_reg == `OVT_LOG_LAST) ? {`OVT_LOG_AW{1'b0}} :
        wr_ptr_reg + 1'b1; // [R14]
      if (log_count_o != `OVT_LOG_DEPTH) begin
        log_count_o <= log_count_o + 1'b1;
      end
    end
  end

  ovt_log_mem #(
    .WIDTH(`OVT_REC_W),
    .DEPTH(`OVT_LOG_DEPTH),
    .AW(`OVT_LOG_AW)
  ) u_log (
    .clock_i(clock_i),
    .enable_i(enable_i),
    .wr_en_i(log_wr),
    .wr_addr_i(wr_ptr_reg),
    .wr_data_i(record),
    .rd_addr_i(log_rd_addr_i),
    .rd_data_o(log_rd_data_o)
  );
endmodule // ovt_stage

// ---- ovt_stage_props.sv ----
/* assertions for one overvoltage stage: start, block, trip and event timing.
   assumes it is bound to ovt_stage, with rst_n_i active low. */
`timescale 1ns/100ps
module ovt_stage_props #(
  parameter [1:0] STAGE_ID = 2'h0
) (
  input wire clock_i,
  input wire rst_n_i,
  input wire enable_i,
  input wire pickup_i,
  input wire block_i,
  input wire [1:0] delay_type_i,
  input wire [17:0] op_delay_steps_i,
  input wire [1:0] delayed_release_i,
  input wire [2:0] on_mask_i,
  input wire [2:0] off_mask_i,
  input wire start_o,
  input wire trip_o,
  input wire blocked_o,
  input wire event_valid_o,
  input wire [1:0] event_stage_o,
  input wire [2:0] event_code_o,
  input wire [3:0] log_count_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_active;
    pickup_i && !block_i && enable_i;
  endsequence
  sequence s_start_ev;
    ##[1:4] (event_valid_o && event_code_o == 3'h0);
  endsequence
  property p_start; s_active |=> start_o; endproperty
  property p_blk; pickup_i && block_i && enable_i |=> blocked_o && !start_o; endproperty
  property p_inst;
    $rose(start_o) && op_delay_steps_i == 18'h00000 && delay_type_i != 2'h2 |-> trip_o;
  endproperty
  property p_nodrop; enable_i && !pickup_i && delayed_release_i != 2'h2 |=> !start_o; endproperty
  property p_cause; $rose(trip_o) |-> $past(pickup_i) && !$past(block_i); endproperty
  property p_stage; event_valid_o |-> event_stage_o == STAGE_ID && event_code_o <= 3'h5; endproperty
  property p_start_ev; $rose(start_o) && on_mask_i[0] |-> s_start_ev; endproperty
  property p_mask;
    event_valid_o |-> (event_code_o[0] ? off_mask_i[event_code_o[2:1]]
                                        : on_mask_i[event_code_o[2:1]]);
  endproperty
  property p_logcnt; log_count_o <= 4'hC; endproperty
  a_start: assert property (p_start) else $error("start missing after pick-up");
  a_blk: assert property (p_blk) else $error("blocked not raised");
  a_inst: assert property (p_inst) else $error("instant trip late");
  a_nodrop: assert property (p_nodrop) else $error("start held without delay");
  a_cause: assert property (p_cause) else $error("trip without pick-up");
  a_stage: assert property (p_stage) else $error("bad event identity");
  a_start_ev: assert property (p_start_ev) else $error("start event missing");
  a_mask: assert property (p_mask) else $error("masked event forwarded");
  a_logcnt: assert property (p_logcnt) else $error("log count above depth");
endmodule // ovt_stage_props

bind ovt_stage ovt_stage_props #(.STAGE_ID(STAGE_ID)) ovt_stage_props_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .enable_i(enable_i), .pickup_i(pickup_i),
  .block_i(block_i), .delay_type_i(delay_type_i), .op_delay_steps_i(op_delay_steps_i),
  .delayed_release_i(delayed_release_i), .on_mask_i(on_mask_i), .off_mask_i(off_mask_i),
  .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .event_valid_o(event_valid_o),
  .event_stage_o(event_stage_o), .event_code_o(event_code_o), .log_count_o(log_count_o));

// ---- ovt_pickup_model.sv ----
/* pick-up comparator and measurement source in front of the stage.
   assumes the bench moves level_i away from the rising edge. */
`timescale 1ns/100ps
module ovt_pickup_model #(
  parameter [15:0] THRESHOLD = 16'h1000
) (
  input wire clock_i,
  input wire [15:0] level_i,
  output wire pickup_o,
  output reg [47:0] ms_o,
  output reg [15:0] pre20_o,
  output reg [15:0] pre200_o
);
  assign pickup_o = level_i > THRESHOLD;
  initial begin
    ms_o = 48'h0;
    pre20_o = 16'h0;
    pre200_o = 16'h0;
  end
  // history taps are one cycle apart, a stand-in for the real averaging
  always @(posedge clock_i) begin
    ms_o <= ms_o + 48'h1;
    pre20_o <= level_i;
    pre200_o <= pre20_o;
  end
endmodule // ovt_pickup_model

// ---- ovt_stage_test.sv ----
/* self-checking bench for one overvoltage stage with a short tick.
   assumes the pick-up model and the bound checker are compiled first. */
`timescale 1ns/100ps
module ovt_stage_test;
  localparam TICK = 10;
  localparam [15:0] HI = 16'h2000;
  localparam [15:0] LO = 16'h0100;
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg block = 1'b0;
  reg [15:0] level = LO;
  reg [1:0] dtype = 2'h1, drel = 2'h1, tres = 2'h2, cont = 2'h1;
  reg [17:0] op = 18'h00003;
  reg [12:0] k = 13'h0001;
  reg [23:0] den = 24'h010000;
  reg [14:0] rel = 15'h0004;
  reg [3:0] rd = 4'h0;
  reg ena = 1'b1;
  reg [2:0] offm = 3'h0;
  wire ev_valid;
  wire [1:0] ev_stage;
  wire [2:0] ev_code;
  wire [47:0] ev_time;
  wire [15:0] ev_volt, ev_pre20, ev_pre200;
  wire [18:0] ev_rem;
  reg [1:0] cap_stage = 2'h0;
  reg [2:0] cap_code = 3'h0;
  reg [47:0] cap_time = 48'h0, cap_ms = 48'h0;
  reg [15:0] cap_volt = 16'h0, cap_pre20 = 16'h0, cap_pre200 = 16'h0;
  reg [18:0] cap_rem = 19'h0;
  integer ev_n = 0;
  wire pickup, start, trip, blocked;
  wire [47:0] ms;
  wire [15:0] p20, p200;
  wire [3:0] cnt;
  wire [123:0] rec;
  integer mismatches = 0, compares = 0, cycles = 0, n;
  ovt_pickup_model ovt_pickup_model_i (.clock_i(clock_i), .level_i(level), .pickup_o(pickup),
    .ms_o(ms), .pre20_o(p20), .pre200_o(p200));
  ovt_stage #(.STAGE_ID(2'h2), .TICK_CYCLES(TICK)) ovt_stage_i (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .enable_i(ena), .pickup_i(pickup), .block_i(block),
    .delay_type_i(dtype), .op_delay_steps_i(op), .time_dial_k_i(k), .ratio_pow_minus1_i(den),
    .release_steps_i(rel), .delayed_release_i(drel), .timer_reset_i(tres),
    .continue_count_i(cont), .on_mask_i(3'h7), .off_mask_i(offm), .timestamp_i(ms),
    .fault_type_i(3'h3), .volt_now_i(level), .volt_pre20_i(p20), .volt_pre200_i(p200),
    .setting_group_i(3'h1), .log_rd_addr_i(rd), .start_o(start), .trip_o(trip),
    .blocked_o(blocked), .event_valid_o(ev_valid), .event_stage_o(ev_stage),
    .event_code_o(ev_code), .event_time_o(ev_time), .event_volt_o(ev_volt),
    .event_pre20_o(ev_pre20), .event_pre200_o(ev_pre200),
    .remaining_steps_o(ev_rem), .log_count_o(cnt), .log_rd_data_o(rec));
  //--------------------------------------------------------------
  // clock, hang guard and helpers
  //--------------------------------------------------------------
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  // forwarded events are caught away from the edge that launches them
  always @(negedge clock_i) begin
    if (ev_valid === 1'b1) begin
      ev_n = ev_n + 1;
      cap_stage = ev_stage;
      cap_code = ev_code;
      cap_time = ev_time;
      cap_ms = ms;
      cap_volt = ev_volt;
      cap_pre20 = ev_pre20;
      cap_pre200 = ev_pre200;
      cap_rem = ev_rem;
    end
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %0s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge clock_i);
  endtask
  task to_trip;
    n = 0;
    while (trip !== 1'b1 && n < 400) begin
      cyc(1);
      n = n + 1;
    end
  endtask
  // the long wait lets the slowest release count in these tests run out
  task quiet;
    level = LO;
    block = 1'b0;
    cyc(150);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //--------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------
  initial begin
    cyc(10);
    rst_n_i = 1'b1;
    cyc(2);
    level = HI;
    to_trip;
    chk("fixed delay", 1, n >= 20 && n <= 31);
    level = LO;
    cyc(1);
    chk("start clear", 0, start);
    chk("trip clear", 0, trip);
    quiet;
    chk("event count", 2, ev_n);
    chk("event code", 2, cap_code);
    chk("event stage", 2, cap_stage);
    chk("event remaining", 0, cap_rem);
    chk("event time", cap_ms[31:0] - 1, cap_time[31:0]);
    op = 18'h00000;
    level = HI;
    cyc(1);
    chk("instant start", 1, start);
    chk("instant trip", 1, trip);
    quiet;
    dtype = 2'h2;
    level = HI;
    to_trip;
    chk("inverse delay", 1, n >= 10 && n <= 21);
    quiet;
    dtype = 2'h1;
    offm = 3'h4;
    block = 1'b1;
    level = HI;
    cyc(1);
    chk("blocked", 1, blocked);
    chk("blocked start", 0, start);
    cyc(3);
    chk("block event", 4, cap_code);
    chk("event voltage", HI, cap_volt);
    chk("event pre20", HI, cap_pre20);
    chk("event pre200", HI, cap_pre200);
    quiet;
    chk("block off event", 5, cap_code);
    op = 18'h000C8;
    drel = 2'h2;
    level = HI;
    cyc(5);
    level = LO;
    n = 0;
    while (start === 1'b1 && n < 200) begin
      cyc(1);
      n = n + 1;
    end
    chk("release hold", 1, n >= 40 && n <= 51);
    chk("start remaining", 1, cap_rem >= 199 && cap_rem <= 200);
    quiet;
    drel = 2'h1;
    op = 18'h00004;
    rel = 15'h0006;
    for (int i = 0; i < 2; i++) begin
      tres = (i == 0) ? 2'h2 : 2'h1;
      level = HI;
      cyc(25);
      level = LO;
      cyc(10);
      level = HI;
      to_trip;
      chk("timer reset", 1, (i == 0) ? (n <= 21) : (n >= 30));
      quiet;
    end
    tres = 2'h2;
    cont = 2'h2;
    op = 18'h00003;
    rel = 15'h000A;
    level = HI;
    cyc(5);
    level = LO;
    cyc(60);
    chk("no trip in release", 0, trip);
    level = HI;
    to_trip;
    chk("continued count", 1, n <= 10);
    quiet;
    chk("log count", 12, cnt);
    ena = 1'b0;
    level = HI;
    cyc(5);
    chk("frozen start", 0, start);
    ena = 1'b1;
    cyc(1);
    chk("thawed start", 1, start);
    quiet;
    rd = 4'h0;
    cyc(2);
    chk("log on event", 0, rec[75:73]);
    chk("log fault type", 3, rec[72:70]);
    chk("log group", 1, rec[2:0]);
    rd = 4'h4;
    cyc(2);
    chk("log trip event", 2, rec[75:73]);
    chk("log remaining", 0, rec[21:3]);
    wrap_up;
  end
endmodule // ovt_stage_test
